/* File: core/srm_pkg.sv */
// constants and state types for the special register map
package srm_pkg;
  localparam logic [7:0] ADDR_DPL      = 8'h82;
  localparam logic [7:0] ADDR_DPH      = 8'h83;
  localparam logic [7:0] ADDR_CORE_CLOCK_DIVIDER     = 8'h95;
  localparam logic [7:0] ADDR_AUX      = 8'ha2;
  localparam logic [7:0] ADDR_COMPARATOR_ONE_CONTROL     = 8'hac;
  localparam logic [7:0] ADDR_COMPARATOR_TWO_CONTROL     = 8'had;
  localparam logic [7:0] ADDR_BRGCTL   = 8'hbd;
  localparam logic [7:0] ADDR_BDIV_LO  = 8'hbe;
  localparam logic [7:0] ADDR_BDIV_HI  = 8'hbf;
  localparam logic [7:0] ADDR_TW_CTL   = 8'hd8;
  localparam logic [7:0] ADDR_TW_DATA  = 8'hda;
  localparam logic [7:0] ADDR_TW_ADR   = 8'hdb;
  localparam logic [7:0] ADDR_TW_SCLH  = 8'hdd;
  localparam logic [7:0] ADDR_ACC      = 8'he0;
  localparam logic [7:0] ADDR_PMCTL    = 8'he4;
  localparam logic [7:0] ADDR_PMDATA   = 8'he5;
  localparam logic [7:0] ADDR_PMADR_LO = 8'he6;
  localparam logic [7:0] ADDR_PMADR_HI = 8'he7;
  localparam logic [7:0] ADDR_BREG     = 8'hf0;
  // reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_PMCTL     = 8'h70;
  // writable bit masks; cleared bits are reserved or fixed zero; MASK_PMSTAT instead marks the live status bits
  localparam logic [7:0] MASK_FULL     = 8'hff;
  localparam logic [7:0] MASK_AUX      = 8'hf9;
  localparam logic [7:0] MASK_CMP      = 8'h3f;
  localparam logic [7:0] MASK_BRGCTL   = 8'h03;
  localparam logic [7:0] MASK_TW_CTL   = 8'h7d;
  localparam logic [7:0] MASK_PMSTAT   = 8'h8f;
  // field positions
  localparam int BIT_BAUD_SRC          = 1;
  localparam int BIT_BAUD_EN           = 0;
  localparam int BIT_PM_BUSY           = 7;
  // bit-addressable base addresses are multiples of eight
  localparam logic [7:0] BITADDR_LIMIT = 8'h80;
  localparam int NUM_REGS              = 19;
  typedef enum logic [1:0] {SRM_IDLE, SRM_CMD} srm_pm_e;
endpackage

/* File: core/srm_regfile.sv */
// small register store with registered read data
module srm_regfile
  import srm_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             we_i,
  input  wire logic [4:0]       widx_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic [4:0]       ridx_i,
  input  wire logic [7:0]       rst_val_i [NUM_REGS],
  output logic      [7:0]       rdata_o,
  output logic      [7:0]       q_o [NUM_REGS]
);
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] mem;
    logic [7:0]               rd;
  } srm_rf_s;
  srm_rf_s rf_reg;
  srm_rf_s rf_next;

  // write port and registered read
  always_comb begin
    rf_next = rf_reg;
    if (we_i && widx_i < 5'(NUM_REGS)) begin
      rf_next.mem[widx_i] = wdata_i;
    end
    rf_next.rd = (ridx_i < 5'(NUM_REGS)) ? rf_reg.mem[ridx_i] : RST_ZERO;
  end

  // reset loads every entry from its reset constant
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        rf_reg.mem[i] <= rst_val_i[i];
      end
      rf_reg.rd <= RST_ZERO;
    end else begin
      rf_reg <= rf_next;
    end
  end

  assign rdata_o = rf_reg.rd;
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_q
      assign q_o[g] = rf_reg.mem[g];
    end
  endgenerate
endmodule

/* File: core/srm_special_register_map.sv */
// special register bank with bit access and program memory control
// Notes on behaviour
// - reserved bits written as zero; reads of them return zero here
// - fixed-zero bits always read back as zero
// - fixed-one bits always read back as one
// - reserved bits kept unstored so later versions may give them meaning
// - bit-addressable registers map bit n to bit address base plus n
// - reading E4H returns busy and four error flags; reset reads 70
// - writing E4H is an 8-bit command; status is unchanged by it
// - program memory address high E7H, low E6H, data E5H reset 00
// - data pointer high 83H, low 82H, both reset 00
// - baud divisor low BEH high BFH; control BDH source bit1 enable bit0
module srm_special_register_map
  import srm_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        bit_wr_i,
  input  wire logic        bit_rd_i,
  input  wire logic [7:0]  bit_addr_i,
  input  wire logic        bit_val_i,
  input  wire logic [3:0]  pm_status_flags_i,
  input  wire logic        pm_busy_i,
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             bit_rdata_o,
  output logic      [7:0]  pm_command_o,
  output logic             pm_command_valid_o,
  output logic      [15:0] data_pointer_pair_o,
  output logic      [15:0] pm_address_o,
  output logic      [7:0]  pm_data_o,
  output logic      [15:0] baud_divisor_o,
  output logic             baud_source_select_o,
  output logic             baud_divider_enable_o
);
  // decode an address to a store index; 31 means undefined
  function automatic logic [4:0] reg_index(input logic [7:0] a);
    case (a)
      ADDR_DPL:      reg_index = 5'h00;
      ADDR_DPH:      reg_index = 5'h01;
      ADDR_CORE_CLOCK_DIVIDER:     reg_index = 5'h02;
      ADDR_AUX:      reg_index = 5'h03;
      ADDR_COMPARATOR_ONE_CONTROL:     reg_index = 5'h04;
      ADDR_COMPARATOR_TWO_CONTROL:     reg_index = 5'h05;
      ADDR_BRGCTL:   reg_index = 5'h06;
      ADDR_BDIV_LO:  reg_index = 5'h07;
      ADDR_BDIV_HI:  reg_index = 5'h08;
      ADDR_TW_CTL:   reg_index = 5'h09;
      ADDR_TW_DATA:  reg_index = 5'h0a;
      ADDR_TW_ADR:   reg_index = 5'h0b;
      ADDR_TW_SCLH:  reg_index = 5'h0c;
      ADDR_ACC:      reg_index = 5'h0d;
      ADDR_PMCTL:    reg_index = 5'h0e;
      ADDR_PMDATA:   reg_index = 5'h0f;
      ADDR_PMADR_LO: reg_index = 5'h10;
      ADDR_PMADR_HI: reg_index = 5'h11;
      ADDR_BREG:     reg_index = 5'h12;
      default:       reg_index = 5'h1f;
    endcase
  endfunction

  // writable mask per address; reserved and fixed bits never stored
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    case (a)
      ADDR_AUX:              wr_mask = MASK_AUX;
      ADDR_COMPARATOR_ONE_CONTROL, ADDR_COMPARATOR_TWO_CONTROL:  wr_mask = MASK_CMP;
      ADDR_BRGCTL:           wr_mask = MASK_BRGCTL;
      ADDR_TW_CTL:           wr_mask = MASK_TW_CTL;
      default:               wr_mask = MASK_FULL;
    endcase
  endfunction

  // only the accumulator, two-wire control and B register answer bit access
  function automatic logic bit_capable(input logic [7:0] base);
    bit_capable = (base == ADDR_ACC) || (base == ADDR_TW_CTL) || (base == ADDR_BREG);
  endfunction

  // fixed-one bit positions per address; none exist in this part of the map yet
  function automatic logic [7:0] fixed_ones(input logic [7:0] a);
    case (a)
      default: fixed_ones = RST_ZERO;
    endcase
  endfunction

  typedef struct packed {
    srm_pm_e    pm_state;
    logic [7:0] cmd;
    logic       cmd_vld;
    logic       rvalid;
    logic       bit_rd;
    logic [7:0] rd_addr;
    logic [7:0] status;
    logic [2:0] rd_pos;
  } srm_state_s;
  srm_state_s st_reg;
  srm_state_s st_next;

  logic [7:0] rst_vals [NUM_REGS];
  logic [7:0] q [NUM_REGS];
  logic [7:0] store_rd;
  logic       we;
  logic [4:0] widx;
  logic [7:0] wdat;
  logic [7:0] bit_base;
  logic [2:0] bit_pos;
  logic [7:0] bit_cur;
  logic [7:0] rd_sel_addr;
  logic [7:0] status_rd;

  // reset values: all zero except the program memory control location
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_rst
      assign rst_vals[g] = (g == 14) ? RST_PMCTL : RST_ZERO;
    end
  endgenerate

  assign bit_base = {bit_addr_i[7:3], 3'h0};
  assign bit_pos  = bit_addr_i[2:0];
  assign bit_cur  = q[reg_index(bit_base)];

  // one write port: a byte write to a stored register wins over a bit write in the same cycle
  always_comb begin
    we   = 1'b0;
    widx = 5'h1f;
    wdat = RST_ZERO;
    if (wr_i && addr_i != ADDR_PMCTL && reg_index(addr_i) != 5'h1f) begin
      we   = 1'b1;
      widx = reg_index(addr_i);
      wdat = wdata_i & wr_mask(addr_i);
    end else if (bit_wr_i && bit_addr_i >= BITADDR_LIMIT && bit_capable(bit_base)) begin
      we   = 1'b1;
      widx = reg_index(bit_base);
      wdat = bit_cur;
      wdat[bit_pos] = bit_val_i;
      wdat = wdat & wr_mask(bit_base);
    end
  end

  // status location takes busy and flags live from the flash controller, bits 6:4 from the store
  always_comb begin
    status_rd = q[14] & ~MASK_PMSTAT;
    status_rd[BIT_PM_BUSY] = pm_busy_i;
    status_rd[3:0] = pm_status_flags_i;
  end

  assign rd_sel_addr = bit_rd_i ? bit_base : addr_i;

  srm_regfile u_store (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .we_i      (we),
    .widx_i    (widx),
    .wdata_i   (wdat),
    .ridx_i    (reg_index(rd_sel_addr)),
    .rst_val_i (rst_vals),
    .rdata_o   (store_rd),
    .q_o       (q)
  );

  // command capture and read tracking
  always_comb begin
    st_next = st_reg;
    st_next.cmd_vld = 1'b0;
    st_next.rvalid  = rd_i | bit_rd_i;
    st_next.bit_rd  = bit_rd_i;
    st_next.rd_addr = rd_sel_addr;
    st_next.status  = status_rd;
    st_next.rd_pos  = bit_pos; // sampled with the read so it lines up with store data
    case (st_reg.pm_state)
      SRM_IDLE: begin
        if (wr_i && addr_i == ADDR_PMCTL) begin
          st_next.cmd      = wdata_i;
          st_next.cmd_vld  = 1'b1;
          st_next.pm_state = SRM_CMD;
        end
      end
      SRM_CMD: begin
        st_next.pm_state = SRM_IDLE;
        if (wr_i && addr_i == ADDR_PMCTL) begin
          st_next.cmd      = wdata_i;
          st_next.cmd_vld  = 1'b1;
          st_next.pm_state = SRM_CMD;
        end
      end
      default: st_next.pm_state = SRM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= '{pm_state: SRM_IDLE, cmd: RST_ZERO, cmd_vld: 1'b0,
                  rvalid: 1'b0, bit_rd: 1'b0, rd_addr: RST_ZERO,
                  status: RST_PMCTL, rd_pos: 3'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  logic [7:0] rd_byte;

  // undefined addresses read zero; masked bits read zero; fixed-one bits forced
  always_comb begin
    if (st_reg.rd_addr == ADDR_PMCTL) begin
      rd_byte = st_reg.status;
    end else if (reg_index(st_reg.rd_addr) == 5'h1f) begin
      rd_byte = RST_ZERO;
    end else begin
      rd_byte = (store_rd & wr_mask(st_reg.rd_addr)) | fixed_ones(st_reg.rd_addr);
    end
  end

  assign rdata_o            = st_reg.rvalid ? rd_byte : RST_ZERO;
  assign rvalid_o           = st_reg.rvalid;
  assign bit_rdata_o        = st_reg.bit_rd & rd_byte[st_reg.rd_pos];
  assign pm_command_o       = st_reg.cmd;
  assign pm_command_valid_o = st_reg.cmd_vld;
  assign data_pointer_pair_o = {q[1], q[0]};
  assign pm_address_o       = {q[17], q[16]};
  assign pm_data_o          = q[15];
  assign baud_divisor_o     = {q[8], q[7]};
  assign baud_source_select_o  = q[6][BIT_BAUD_SRC];
  assign baud_divider_enable_o = q[6][BIT_BAUD_EN];

  chk_read_latency: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && !bit_rd_i) |=> rvalid_o)
    else $error("read not answered next cycle");
  chk_cmd_capture: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == ADDR_PMCTL) |=> (pm_command_valid_o && pm_command_o == $past(wdata_i)))
    else $error("command not captured");
  chk_cmd_no_status: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_PMCTL) |=> rdata_o == {$past(pm_busy_i), RST_PMCTL[6:4],
      $past(pm_status_flags_i)})
    else $error("status read wrong");
  chk_data_pointer_pair_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == ADDR_DPH) |=> ##1 data_pointer_pair_o[15:8] == $past(wdata_i, 2))
    else $error("data pointer high not written");
  chk_baud_ctl_mask: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_BRGCTL) |=> rdata_o[7:2] == 6'h00)
    else $error("reserved baud control bits nonzero");
  chk_aux_zero_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_AUX) |=> rdata_o[2] == 1'b0)
    else $error("fixed zero bit read as one");
  chk_undef_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && !bit_rd_i && reg_index(addr_i) == 5'h1f) |=> rdata_o == RST_ZERO)
    else $error("undefined address not zero");
  chk_reset_hold: assert property (@(posedge mclk_i)
    $fell(srst_i) |-> (pm_address_o == 16'h0000 && baud_divisor_o == 16'h0000))
    else $error("reset values not loaded");
  chk_bit_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    (bit_wr_i && !wr_i && bit_addr_i[7:3] == 5'h1c) |=> ##1
      (q[13][$past(bit_addr_i[2:0], 2)] == $past(bit_val_i, 2)))
    else $error("accumulator bit write lost");
  // strobes last one cycle; stored values hold until written
  chk_rvalid_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(rd_i || bit_rd_i) |=> !rvalid_o)
    else $error("read valid without a read");
  chk_cmd_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(wr_i && addr_i == ADDR_PMCTL) |=> !pm_command_valid_o)
    else $error("command strobe without a write");
  chk_cmd_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(wr_i && addr_i == ADDR_PMCTL) |=> $stable(pm_command_o))
    else $error("command byte changed without a write");
  chk_status_store: assert property (@(posedge mclk_i) disable iff (srst_i)
    q[14] == RST_PMCTL)
    else $error("command write reached the status store");
  chk_tw_reserved: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_TW_CTL) |=> (rdata_o[7] == 1'b0 && rdata_o[1] == 1'b0))
    else $error("reserved two-wire control bits nonzero");
  chk_cmp_reserved: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_i && (addr_i == ADDR_COMPARATOR_ONE_CONTROL || addr_i == ADDR_COMPARATOR_TWO_CONTROL)) |=> rdata_o[7:6] == 2'h0)
    else $error("reserved comparator bits nonzero");
  chk_pmadr_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(wr_i && (addr_i == ADDR_PMADR_LO || addr_i == ADDR_PMADR_HI))
      |=> $stable(pm_address_o))
    else $error("program address changed without a write");
  chk_data_pointer_pair_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(wr_i && (addr_i == ADDR_DPL || addr_i == ADDR_DPH))
      |=> $stable(data_pointer_pair_o))
    else $error("data pointer changed without a write");
  chk_baud_ctl_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == ADDR_BRGCTL) |=> (baud_divider_enable_o == $past(wdata_i[BIT_BAUD_EN])
      && baud_source_select_o == $past(wdata_i[BIT_BAUD_SRC])))
    else $error("baud control bits not written");
  chk_bit_ignore: assert property (@(posedge mclk_i) disable iff (srst_i)
    (bit_wr_i && !wr_i && bit_addr_i[7:3] == 5'h14) |=> $stable(q[3]))
    else $error("bit write reached a byte-only register");
  chk_pmdata_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !(wr_i && addr_i == ADDR_PMDATA) |=> $stable(pm_data_o))
    else $error("program data changed without a write");

  // main scenarios
  cov_cmd: cover property (@(posedge mclk_i) pm_command_valid_o);
  cov_bit_rd: cover property (@(posedge mclk_i) bit_rd_i ##1 bit_rdata_o);
  cov_baud_en: cover property (@(posedge mclk_i) baud_divider_enable_o);
  cov_status_busy: cover property (@(posedge mclk_i) rvalid_o && rdata_o[BIT_PM_BUSY]);
  cov_bit_wr_acc: cover property (@(posedge mclk_i) bit_wr_i && bit_addr_i[7:3] == 5'h1c);
endmodule

/* File: tb/srm_core_model.sv */
// processor core model issuing special register accesses
module srm_core_model
  import srm_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       bit_rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            bit_wr_o,
  output logic            bit_rd_o,
  output logic      [7:0] bit_addr_o,
  output logic            bit_val_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {wr_o, rd_o, bit_wr_o, bit_rd_o, bit_val_o} = 5'h00;
    {addr_o, wdata_o, bit_addr_o} = 24'h000000;
  end
  // kind is {wr, rd, bit_wr, bit_rd}; one strobe, taken at the next rising edge
  task automatic cycle(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] m);
    @(negedge mclk_i);
    {wr_o, rd_o, bit_wr_o, bit_rd_o} = k;
    addr_o = a;
    bit_addr_o = a;
    wdata_o = d & m;
    bit_val_o = d[0];
    @(negedge mclk_i);
    {wr_o, rd_o, bit_wr_o, bit_rd_o} = 4'h0;
    addr_o = ~a; // released address and data lines are inverted; bit_val_o keeps its last value
    bit_addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
  // read with a bounded wait for the answer
  task automatic read(input logic [3:0] k, input logic [7:0] a, output logic [7:0] q,
                      output logic ok);
    cycle(k, a, 8'h00, 8'h00);
    ok = 1'b0;
    q = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        q = (k == 4'h1) ? {7'h00, bit_rdata_i} : rdata_i;
      end else @(negedge mclk_i);
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the special register map
module tb_top
  import srm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, srst = 1'b1, wr, rd, bwr, brd, bval, busy = 1'b0, rv, brdat, cv;
  logic [7:0]  addr, wdat, baddr, rdat, cmd, pdat;
  logic [3:0]  flags = 4'h0;
  logic [15:0] data_pointer_pair, padr, bdiv;
  logic        bsrc, ben;
  int          failures = 0, cmp_count = 0, cmd_pulses = 0;
  logic [7:0]  t_a [18] = '{8'h82, 8'h83, 8'h95, 8'ha2, 8'hac, 8'had, 8'hbd, 8'hbe, 8'hbf,
                            8'hd8, 8'hda, 8'hdb, 8'hdd, 8'he0, 8'he5, 8'he6, 8'he7, 8'hf0};
  logic [7:0]  t_m [18] = '{8'hff, 8'hff, 8'hff, 8'hf9, 8'h3f, 8'h3f, 8'h03, 8'hff, 8'hff,
                            8'h7d, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // clock at 25 MHz
  initial begin
    forever #20 mclk = ~mclk;
  end
  srm_core_model i_core (.mclk_i(mclk), .rvalid_i(rv), .rdata_i(rdat), .bit_rdata_i(brdat),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdat), .bit_wr_o(bwr), .bit_rd_o(brd),
    .bit_addr_o(baddr), .bit_val_o(bval));
  srm_special_register_map i_dut (.mclk_i(mclk), .srst_i(srst), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdat), .bit_wr_i(bwr), .bit_rd_i(brd), .bit_addr_i(baddr),
    .bit_val_i(bval), .pm_status_flags_i(flags), .pm_busy_i(busy), .rdata_o(rdat),
    .rvalid_o(rv), .bit_rdata_o(brdat), .pm_command_o(cmd), .pm_command_valid_o(cv),
    .data_pointer_pair_o(data_pointer_pair), .pm_address_o(padr), .pm_data_o(pdat),
    .baud_divisor_o(bdiv), .baud_source_select_o(bsrc), .baud_divider_enable_o(ben));
  // count command strobes
  always @(posedge mclk) if (cv === 1'b1) cmd_pulses <= cmd_pulses + 1;
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    i_core.cycle(4'h8, a, d, 8'hff);
  endtask
  // byte or bit read compared against an expected value
  task automatic rdc(input logic [3:0] k, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    i_core.read(k, a, q, ok);
    if (!ok) begin
      failures++;
      complete_run();
    end
    check({8'h00, q}, {8'h00, e}, "read data");
  endtask
  task automatic do_reset();
    @(negedge mclk);
    srst = 1'b1;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
  endtask
  task automatic t_reset();
    foreach (t_a[i]) rdc(4'h4, t_a[i], 8'h00);
    rdc(4'h4, 8'he4, 8'h70);
    check(data_pointer_pair, 16'h0000, "data pointer reset");
    check(padr, 16'h0000, "program address reset");
    check({8'h00, pdat}, 16'h0000, "program data reset");
    check(bdiv, 16'h0000, "baud divisor reset");
    check({14'h0000, bsrc, ben}, 16'h0000, "baud control reset");
    check({8'h00, cmd}, 16'h0000, "command byte reset");
    $display("test reset values done");
  endtask
  task automatic t_rw();
    foreach (t_a[i]) begin
      i_core.cycle(4'h8, t_a[i], 8'ha5, t_m[i]);
      rdc(4'h4, t_a[i], 8'ha5 & t_m[i]);
      i_core.cycle(4'h8, t_a[i], 8'h5a, t_m[i]);
      rdc(4'h4, t_a[i], 8'h5a & t_m[i]);
    end
    wr8(8'hbd, 8'hff);
    rdc(4'h4, 8'hbd, 8'h03);
    wr8(8'h90, 8'hff);
    rdc(4'h4, 8'h90, 8'h00);
    $display("test read write done");
  endtask
  task automatic t_outputs();
    wr8(8'h83, 8'h12);
    wr8(8'h82, 8'h34);
    wr8(8'he7, 8'h56);
    wr8(8'he6, 8'h78);
    wr8(8'he5, 8'h9a);
    wr8(8'hbf, 8'hbc);
    wr8(8'hbe, 8'hde);
    wr8(8'hbd, 8'h02);
    repeat (2) @(negedge mclk);
    check(data_pointer_pair, 16'h1234, "data pointer");
    check(padr, 16'h5678, "program address");
    check({8'h00, pdat}, 16'h009a, "program data");
    check(bdiv, 16'hbcde, "baud divisor");
    check({14'h0000, bsrc, ben}, 16'h0002, "baud control");
    wr8(8'hbd, 8'h01);
    repeat (2) @(negedge mclk);
    check({14'h0000, bsrc, ben}, 16'h0001, "baud control");
    $display("test outputs done");
  endtask
  task automatic t_cmd();
    int n;
    for (int i = 0; i < 4; i++) begin
      n = cmd_pulses;
      busy = i[0];
      flags = 4'h5 << i;
      wr8(8'he4, 8'hc3 + 8'(i));
      repeat (2) @(negedge mclk);
      check(16'(cmd_pulses - n), 16'h1, "command pulses");
      check({8'h00, cmd}, 16'h00c3 + 16'(i), "command byte");
      rdc(4'h4, 8'he4, {i[0], 3'h7, 4'h5 << i});
    end
    $display("test program control done");
  endtask
  task automatic t_bit();
    wr8(8'he0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      i_core.cycle(4'h2, 8'he0 + 8'(b), 8'h01, 8'hff);
      rdc(4'h1, 8'he0 + 8'(b), 8'h01);
      rdc(4'h4, 8'he0, 8'((2 << b) - 1));
    end
    i_core.cycle(4'h2, 8'he0, 8'h00, 8'hff);
    rdc(4'h4, 8'he0, 8'hfe);
    wr8(8'hf0, 8'h00);
    i_core.cycle(4'h2, 8'hf3, 8'h01, 8'hff);
    rdc(4'h4, 8'hf0, 8'h08);
    wr8(8'hd8, 8'h00);
    i_core.cycle(4'h2, 8'hde, 8'h01, 8'hff);
    rdc(4'h4, 8'hd8, 8'h40);
    i_core.cycle(4'h2, 8'ha2, 8'h01, 8'hff);
    rdc(4'h1, 8'ha2, 8'h00);
    $display("test bit access done");
  endtask
  // bound on the whole run
  initial begin
    #800000;
    failures++;
    complete_run();
  end
  initial begin
    do_reset();
    t_reset();
    t_rw();
    t_outputs();
    t_cmd();
    t_bit();
    busy = 1'b0;
    flags = 4'h0;
    do_reset();
    t_reset();
    complete_run();
  end
endmodule
